// ### verilog/activity_monitor_id_block.sv
`timescale 1ns/1ps
// Overview of operation
// - All registers read-only; writes store nothing
// - Low affinity word mirrors affinity bits 31:0
// - High affinity word at 0xfac mirrors 63:32
// - Component word 0 at 0xff0 reads 0x0d
// - Component word 1: class 0x9, preamble zero
// - Component word 2 reads 0x05 in low byte
// - Component word 3 at 0xffc reads 0xb1
// - Architect code in bits 31:21, split 4+7
// - Descriptor bit 20 always reads one
// - Architecture revision zero in bits 19:16
// - Identifier 0x0a66 in 15:0, at 0xfbc
// - Device type sub-type 0x1 in 7:4
// - Device type at 0xfcc, major 0x6
// - Implementation word: part number in 31:20
// - Major revision in bits 19:16
// - Minor revision in bits 15:12
// - Implementer: continuation, zero bit7, maker code
// - Implementation word readable at 0xe08
// - Peripheral word 0 at 0xfe0: part low byte
module activity_monitor_id_block
    import amon_id_pkg::*;
#(
    parameter logic [11:0] PART_NUMBER = 12'h5a7, // Arbitrary value
    parameter logic [3:0]  MAJOR_REV   = 4'h1,    // Arbitrary value
    parameter logic [3:0]  MINOR_REV   = 4'h3,    // Arbitrary value
    parameter logic [11:0] IMPLEMENTER = 12'h125, // Arbitrary value, bit 7 clear
    parameter logic [10:0] ARCHITECT   = 11'h2a1  // Arbitrary value
)
(
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    // Affinity value from the core, same clock
    input  wire logic [amon_id_pkg::AFF_W-1:0] core_affinity_source,
    // Debug access port
    input  amon_id_pkg::dbg_req_s              dbg_req,
    output amon_id_pkg::dbg_rsp_s              dbg_rsp
);

    // Whole block state
    typedef struct packed {
        dbg_rsp_s rsp;
    } state_s;

    state_s   state_reg;
    state_s   state_next;
    reg_sel_e sel;
    logic [DATA_W-1:0] rom_word;
    logic              rom_hit;

    // Offset decode
    amon_access_decoder u_decoder (
        .offset (dbg_req.addr),
        .sel    (sel)
    );

    // Identification words and affinity mirror
    amon_ident_rom #(
        .PART_NUMBER (PART_NUMBER),
        .MAJOR_REV   (MAJOR_REV),
        .MINOR_REV   (MINOR_REV),
        .IMPLEMENTER (IMPLEMENTER),
        .ARCHITECT   (ARCHITECT)
    ) u_rom (
        .sel                  (sel),
        .core_affinity_source (core_affinity_source),
        .word                 (rom_word),
        .hit                  (rom_hit)
    );

    // Answer logic: one-cycle acknowledge, data held until next answer
    always_comb
    begin
        state_next             = state_reg;
        state_next.rsp.ack     = 1'b0;
        if (dbg_req.valid)
        begin
            state_next.rsp.ack = 1'b1;
            if (dbg_req.write)
            begin
                // Write data is dropped; nothing is stored
                state_next.rsp.rdata         = RDATA_RST;
                state_next.rsp.mapped        = rom_hit;
                state_next.rsp.write_ignored = 1'b1;
            end
            else
            begin
                state_next.rsp.rdata         = rom_word;
                state_next.rsp.mapped        = rom_hit;
                state_next.rsp.write_ignored = 1'b0;
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg.rsp.ack           <= 1'b0;
            state_reg.rsp.mapped        <= 1'b0;
            state_reg.rsp.write_ignored <= 1'b0;
            state_reg.rsp.rdata         <= RDATA_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign dbg_rsp = state_reg.rsp;

    // Helpers read only by the checks below
    logic              rd_req;
    logic [31:0]       aff_lo_w;
    logic [31:0]       aff_hi_w;
    logic [DATA_W-1:0] rdata;

    assign rd_req   = dbg_req.valid && !dbg_req.write;
    assign aff_lo_w = core_affinity_source[31:0];
    assign aff_hi_w = core_affinity_source[63:32];
    assign rdata    = dbg_rsp.rdata;

    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (!rst_n);

    // Reads of a fixed offset yield a fixed word one cycle later
    property read_yields(logic [ADDR_W-1:0] off, logic [DATA_W-1:0] val);
        rd_req && dbg_req.addr == off |=> dbg_rsp.ack && rdata == val;
    endproperty

    sequence write_taken;
        dbg_req.valid && dbg_req.write;
    endsequence

    // Writes answer with zero data and never alter a later read
    write_dropped_a: assert property (write_taken |=> dbg_rsp.ack && dbg_rsp.write_ignored
                                       && rdata == RDATA_RST)
        else $error("write was not dropped");

    write_no_effect_a: assert property (write_taken ##1 (rd_req && dbg_req.addr == OFF_CID0)
                                        |=> rdata == low_byte(CID0_PREAMBLE))
        else $error("write changed a later read");

    aff_low_a: assert property (rd_req && dbg_req.addr == OFF_AFF_LOW |=> rdata == $past(aff_lo_w))
        else $error("low affinity word mismatch");

    aff_high_a: assert property (rd_req && dbg_req.addr == OFF_AFF_HIGH |=> rdata == $past(aff_hi_w))
        else $error("high affinity word mismatch");

    cid0_word_a: assert property (read_yields(OFF_CID0, 32'h0000_000d))
        else $error("component word 0 mismatch");

    cid1_class_a: assert property (rd_req && dbg_req.addr == OFF_CID1
                                   |=> rdata[7:CLASS_LSB] == 4'h9 && rdata[3:0] == 4'h0 && rdata[31:8] == 24'h0)
        else $error("component class mismatch");

    cid2_word_a: assert property (read_yields(OFF_CID2, 32'h0000_0005))
        else $error("component word 2 mismatch");

    cid3_word_a: assert property (read_yields(OFF_CID3, 32'h0000_00b1))
        else $error("component word 3 mismatch");

    arch_architect_a: assert property (rd_req && dbg_req.addr == OFF_ARCH_DESC
                                       |=> rdata[31:ARCH_ARCHITECT_LSB] == ARCHITECT)
        else $error("architect code mismatch");

    arch_present_a: assert property (rd_req && dbg_req.addr == OFF_ARCH_DESC
                                     |=> rdata[ARCH_PRESENT_BIT] == 1'b1)
        else $error("descriptor present bit low");

    arch_revision_a: assert property (rd_req && dbg_req.addr == OFF_ARCH_DESC
                                      |=> rdata[19:ARCH_REVISION_LSB] == 4'h0)
        else $error("architecture revision not zero");

    arch_ident_a: assert property (rd_req && dbg_req.addr == 12'hfbc ##1 dbg_rsp.ack
                                   |-> rdata[15:0] == 16'h0a66)
        else $error("architecture identifier mismatch");

    devtype_sub_a: assert property (rd_req && dbg_req.addr == OFF_DEV_TYPE
                                    |=> rdata[7:4] == 4'h1)
        else $error("device sub-type mismatch");

    devtype_word_a: assert property (read_yields(12'hfcc, 32'h0000_0016))
        else $error("device type word mismatch");

    impl_part_a: assert property (rd_req && dbg_req.addr == OFF_IMPL_ID
                                  |=> rdata[31:IMPL_PART_LSB] == PART_NUMBER)
        else $error("part number field mismatch");

    impl_major_a: assert property (rd_req && dbg_req.addr == OFF_IMPL_ID
                                   |=> rdata[19:IMPL_MAJOR_LSB] == MAJOR_REV)
        else $error("major revision field mismatch");

    impl_minor_a: assert property (rd_req && dbg_req.addr == OFF_IMPL_ID
                                   |=> rdata[15:IMPL_MINOR_LSB] == MINOR_REV)
        else $error("minor revision field mismatch");

    impl_maker_a: assert property (rd_req && dbg_req.addr == OFF_IMPL_ID
                                   |=> rdata[IMPL_RSVD_BIT] == 1'b0 && rdata[11:8] == IMPLEMENTER[11:8]
                                       && rdata[6:0] == IMPLEMENTER[6:0])
        else $error("implementer field mismatch");

    impl_mapped_a: assert property (rd_req && dbg_req.addr == 12'he08 |=> dbg_rsp.mapped)
        else $error("implementation word not mapped");

    pid0_word_a: assert property (rd_req && dbg_req.addr == OFF_PID0
                                  |=> rdata == {24'h00_0000, PART_NUMBER[7:0]})
        else $error("peripheral word 0 mismatch");

    unmapped_zero_a: assert property (rd_req && sel == SEL_NONE
                                      |=> rdata == RDATA_RST && !dbg_rsp.mapped)
        else $error("unmapped read not zero");

    ack_pulse_a: assert property (dbg_req.valid |=> dbg_rsp.ack)
        else $error("request not answered");

    ack_only_req_a: assert property (!dbg_req.valid |=> !dbg_rsp.ack)
        else $error("answer without request");

    idle_hold_a: assert property (!dbg_req.valid [*2] |=> $stable(rdata))
        else $error("read data moved while idle");

    // Main scenarios
    read_arch_c: cover property (rd_req && dbg_req.addr == OFF_ARCH_DESC ##1 dbg_rsp.ack);
    write_seen_c: cover property (write_taken ##1 dbg_rsp.write_ignored);
    back_to_back_c: cover property (rd_req ##1 rd_req ##1 dbg_rsp.ack);
    unmapped_c: cover property (rd_req && sel == SEL_NONE ##1 !dbg_rsp.mapped);

endmodule

// ### verilog/amon_id_pkg.sv
package amon_id_pkg;

    // Debug page geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned AFF_W  = 64;

    // Register offsets within the debug page (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_IMPL_ID   = 12'he08;
    localparam logic [ADDR_W-1:0] OFF_AFF_LOW   = 12'hfa8;
    localparam logic [ADDR_W-1:0] OFF_AFF_HIGH  = 12'hfac;
    localparam logic [ADDR_W-1:0] OFF_ARCH_DESC = 12'hfbc;
    localparam logic [ADDR_W-1:0] OFF_DEV_TYPE  = 12'hfcc;
    localparam logic [ADDR_W-1:0] OFF_PID4      = 12'hfd0;
    localparam logic [ADDR_W-1:0] OFF_PID0      = 12'hfe0;
    localparam logic [ADDR_W-1:0] OFF_PID1      = 12'hfe4;
    localparam logic [ADDR_W-1:0] OFF_PID2      = 12'hfe8;
    localparam logic [ADDR_W-1:0] OFF_PID3      = 12'hfec;
    localparam logic [ADDR_W-1:0] OFF_CID0      = 12'hff0;
    localparam logic [ADDR_W-1:0] OFF_CID1      = 12'hff4;
    localparam logic [ADDR_W-1:0] OFF_CID2      = 12'hff8;
    localparam logic [ADDR_W-1:0] OFF_CID3      = 12'hffc;

    // Fixed field values
    localparam logic [7:0]  CID0_PREAMBLE  = 8'h0d;
    localparam logic [3:0]  CID1_CLASS     = 4'h9;
    localparam logic [3:0]  CID1_PREAMBLE  = 4'h0;
    localparam logic [7:0]  CID2_PREAMBLE  = 8'h05;
    localparam logic [7:0]  CID3_PREAMBLE  = 8'hb1;
    localparam logic        ARCH_PRESENT   = 1'b1;
    localparam logic [3:0]  ARCH_REVISION  = 4'h0;
    localparam logic [15:0] ARCH_IDENT     = 16'h0a66;
    localparam logic [3:0]  DEVTYPE_SUB    = 4'h1;
    localparam logic [3:0]  DEVTYPE_MAJOR  = 4'h6;
    localparam logic        PID2_JEDEC     = 1'b1;
    localparam logic [3:0]  PID3_REVAND    = 4'h0;
    localparam logic [3:0]  PID3_CMOD      = 4'h0;
    localparam logic [3:0]  PID4_SIZE      = 4'h0;
    localparam logic        IMPL_BIT7      = 1'b0;

    // Field positions
    localparam int unsigned ARCH_ARCHITECT_LSB = 21;
    localparam int unsigned ARCH_PRESENT_BIT   = 20;
    localparam int unsigned ARCH_REVISION_LSB  = 16;
    localparam int unsigned IMPL_PART_LSB      = 20;
    localparam int unsigned IMPL_MAJOR_LSB     = 16;
    localparam int unsigned IMPL_MINOR_LSB     = 12;
    localparam int unsigned IMPL_RSVD_BIT      = 7;
    localparam int unsigned CLASS_LSB          = 4;

    // Reset values
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // Registers the decoder can select
    typedef enum logic [3:0] {
        SEL_NONE, SEL_IMPL, SEL_AFF_LO, SEL_AFF_HI, SEL_ARCH, SEL_DEVTYPE, SEL_PID0,
        SEL_PID1, SEL_PID2, SEL_PID3, SEL_PID4, SEL_CID0, SEL_CID1, SEL_CID2, SEL_CID3
    } reg_sel_e;

    // Debug request and answer carriers
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dbg_req_s;

    typedef struct packed {
        logic              ack;
        logic              mapped;
        logic              write_ignored;
        logic [DATA_W-1:0] rdata;
    } dbg_rsp_s;

    // Byte placed in the low lane, upper bits zero
    function automatic logic [DATA_W-1:0] low_byte(input logic [7:0] b);
        return {24'h00_0000, b};
    endfunction

endpackage

// ### verilog/amon_access_decoder.sv
`timescale 1ns/1ps
module amon_access_decoder
    import amon_id_pkg::*;
(
    // Debug page offset
    input  wire logic [amon_id_pkg::ADDR_W-1:0] offset,
    // Selected register
    output amon_id_pkg::reg_sel_e               sel
);

    // Offset to register select; misaligned words map to nothing
    always_comb
    begin
        sel = SEL_NONE;
        if (offset[1:0] == 2'h0)
        begin
            unique case (offset)
                OFF_IMPL_ID:   sel = SEL_IMPL;
                OFF_AFF_LOW:   sel = SEL_AFF_LO;
                OFF_AFF_HIGH:  sel = SEL_AFF_HI;
                OFF_ARCH_DESC: sel = SEL_ARCH;
                OFF_DEV_TYPE:  sel = SEL_DEVTYPE;
                OFF_PID0:      sel = SEL_PID0;
                OFF_PID1:      sel = SEL_PID1;
                OFF_PID2:      sel = SEL_PID2;
                OFF_PID3:      sel = SEL_PID3;
                OFF_PID4:      sel = SEL_PID4;
                OFF_CID0:      sel = SEL_CID0;
                OFF_CID1:      sel = SEL_CID1;
                OFF_CID2:      sel = SEL_CID2;
                OFF_CID3:      sel = SEL_CID3;
                default:       sel = SEL_NONE;
            endcase
        end
    end

endmodule

// ### verilog/amon_ident_rom.sv
`timescale 1ns/1ps
module amon_ident_rom
    import amon_id_pkg::*;
#(
    parameter logic [11:0] PART_NUMBER = 12'h5a7, // Arbitrary value
    parameter logic [3:0]  MAJOR_REV   = 4'h1,    // Arbitrary value
    parameter logic [3:0]  MINOR_REV   = 4'h3,    // Arbitrary value
    parameter logic [11:0] IMPLEMENTER = 12'h125, // Arbitrary value, bit 7 clear
    parameter logic [10:0] ARCHITECT   = 11'h2a1  // Arbitrary value
)
(
    // Selection and live affinity
    input  amon_id_pkg::reg_sel_e              sel,
    input  wire logic [amon_id_pkg::AFF_W-1:0] core_affinity_source,
    // Word read
    output logic [amon_id_pkg::DATA_W-1:0]     word,
    output logic                               hit
);

    // Constant words and live affinity halves
    always_comb
    begin
        word = RDATA_RST;
        hit  = 1'b1;
        unique case (sel)
            SEL_IMPL:    word = {PART_NUMBER, MAJOR_REV, MINOR_REV,
                                 IMPLEMENTER[11:8], IMPL_BIT7, IMPLEMENTER[6:0]};
            SEL_AFF_LO:  word = core_affinity_source[31:0];
            SEL_AFF_HI:  word = core_affinity_source[63:32];
            SEL_ARCH:    word = {ARCHITECT, ARCH_PRESENT, ARCH_REVISION, ARCH_IDENT};
            SEL_DEVTYPE: word = low_byte({DEVTYPE_SUB, DEVTYPE_MAJOR});
            SEL_PID0:    word = low_byte(PART_NUMBER[7:0]);
            SEL_PID1:    word = low_byte({IMPLEMENTER[3:0], PART_NUMBER[11:8]});
            SEL_PID2:    word = low_byte({MINOR_REV, PID2_JEDEC, IMPLEMENTER[6:4]});
            SEL_PID3:    word = low_byte({PID3_REVAND, PID3_CMOD});
            SEL_PID4:    word = low_byte({PID4_SIZE, IMPLEMENTER[11:8]});
            SEL_CID0:    word = low_byte(CID0_PREAMBLE);
            SEL_CID1:    word = low_byte({CID1_CLASS, CID1_PREAMBLE});
            SEL_CID2:    word = low_byte(CID2_PREAMBLE);
            SEL_CID3:    word = low_byte(CID3_PREAMBLE);
            SEL_NONE:
            begin
                word = RDATA_RST;
                hit  = 1'b0;
            end
        endcase
    end

endmodule

// ### tb/debug_reader_model.sv
`timescale 1ns/1ps
module debug_reader_model
(
    // Clock
    input  wire logic                              ref_clk,
    // Commands from the bench
    input  wire logic                              go,
    input  wire logic                              wr,
    input  wire logic [amon_id_pkg::ADDR_W-1:0]    addr,
    input  wire logic [amon_id_pkg::DATA_W-1:0]    wdata,
    // Request toward the block
    output amon_id_pkg::dbg_req_s                  dbg_req
);
    import amon_id_pkg::*;

    logic [31:0] idle_reg = 32'h0000_0000;

    // Filler that changes every cycle, so idle lines never look held
    always_ff @(posedge ref_clk)
    begin
        idle_reg <= idle_reg + 32'h0000_0001;
    end

    // Request is held for the whole cycle the bench asks for it
    always_comb
    begin
        if (go)
        begin
            dbg_req = '{valid: 1'b1, write: wr, addr: addr, wdata: wr ? wdata : ~idle_reg};
        end
        else
        begin
            dbg_req = '{valid: 1'b0, write: idle_reg[0], addr: idle_reg[11:0], wdata: ~idle_reg};
        end
    end
endmodule

// ### tb/activity_monitor_id_block_bench.sv
`timescale 1ns/1ps
module activity_monitor_id_block_bench;
    import amon_id_pkg::*;

    // Identity values, all arbitrary
    localparam logic [11:0] PART  = 12'h6c9;
    localparam logic [3:0]  MAJ   = 4'h3;
    localparam logic [3:0]  MIN   = 4'h5;
    localparam logic [11:0] IMPL  = 12'h17e;
    localparam logic [10:0] ARCH  = 11'h52d;
    localparam logic [63:0] AFF_A = 64'h8000_0102_c0de_0a0b;
    localparam logic [63:0] AFF_B = 64'h7fff_fefd_3f21_f5f4;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              mapped;
    } row_s;

    // Access and expected answer, one row each
    row_s rows [21] = '{
        '{1'b0, 12'he08, {PART, MAJ, MIN, IMPL[11:8], 1'b0, IMPL[6:0]}, 1'b1},
        '{1'b0, 12'hfa8, AFF_A[31:0], 1'b1},
        '{1'b0, 12'hfac, AFF_A[63:32], 1'b1},
        '{1'b0, 12'hfbc, {ARCH, 1'b1, 4'h0, 16'h0a66}, 1'b1},
        '{1'b0, 12'hfcc, 32'h0000_0016, 1'b1},
        '{1'b0, 12'hfe0, {24'h00_0000, PART[7:0]}, 1'b1},
        '{1'b0, 12'hff0, 32'h0000_000d, 1'b1},
        '{1'b0, 12'hff4, 32'h0000_0090, 1'b1},
        '{1'b0, 12'hff8, 32'h0000_0005, 1'b1},
        '{1'b0, 12'hffc, 32'h0000_00b1, 1'b1},
        '{1'b0, 12'hfd0, {28'h000_0000, IMPL[11:8]}, 1'b1},
        '{1'b0, 12'hfe4, {24'h00_0000, IMPL[3:0], PART[11:8]}, 1'b1},
        '{1'b0, 12'hfe8, {24'h00_0000, MIN, 1'b1, IMPL[6:4]}, 1'b1},
        '{1'b0, 12'hfec, 32'h0000_0000, 1'b1},
        '{1'b0, 12'he04, 32'h0000_0000, 1'b0},
        '{1'b0, 12'hfbd, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h000, 32'h0000_0000, 1'b0},
        '{1'b1, 12'hfbc, 32'h0000_0000, 1'b1},
        '{1'b1, 12'hfa8, 32'h0000_0000, 1'b1},
        '{1'b1, 12'h100, 32'h0000_0000, 1'b0},
        '{1'b0, 12'hfbc, {ARCH, 1'b1, 4'h0, 16'h0a66}, 1'b1}
    };

    logic                ref_clk              = 1'b0;
    logic                rst_n                = 1'b0;
    logic [AFF_W-1:0]    core_affinity_source = AFF_A;
    logic                go                   = 1'b0;
    logic                wr                   = 1'b0;
    logic [ADDR_W-1:0]   addr                 = 12'h000;
    logic [DATA_W-1:0]   wdata                = 32'h0000_0000;
    dbg_req_s            dbg_req;
    dbg_rsp_s            dbg_rsp;
    int                  mismatches           = 0;
    int                  comparisons          = 0;

    // Clock, 4 ns period
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    debug_reader_model u_debug_reader_model (
        .ref_clk (ref_clk),
        .go      (go),
        .wr      (wr),
        .addr    (addr),
        .wdata   (wdata),
        .dbg_req (dbg_req)
    );

    activity_monitor_id_block #(
        .PART_NUMBER (PART),
        .MAJOR_REV   (MAJ),
        .MINOR_REV   (MIN),
        .IMPLEMENTER (IMPL),
        .ARCHITECT   (ARCH)
    ) u_activity_monitor_id_block (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .core_affinity_source (core_affinity_source),
        .dbg_req              (dbg_req),
        .dbg_rsp              (dbg_rsp)
    );

    // Compare and count
    task automatic check(input dbg_rsp_s seen, input dbg_rsp_s exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access, then look at the answer cycle
    task automatic issue(input logic w, input logic [ADDR_W-1:0] a);
        @(posedge ref_clk);
        go    <= 1'b1;
        wr    <= w;
        addr  <= a;
        wdata <= 32'hffff_ffff;
        @(posedge ref_clk);
        go    <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic stop_test;
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (2000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i])
        begin
            issue(rows[i].wr, rows[i].addr);
            check(dbg_rsp, '{1'b1, rows[i].mapped, rows[i].wr, rows[i].data});
        end
        // Back to back affinity reads while the source changes
        @(posedge ref_clk);
        go   <= 1'b1;
        wr   <= 1'b0;
        addr <= 12'hfa8;
        @(posedge ref_clk);
        addr                 <= 12'hfac;
        core_affinity_source <= AFF_B;
        @(negedge ref_clk);
        check(dbg_rsp, '{1'b1, 1'b1, 1'b0, AFF_A[31:0]});
        @(posedge ref_clk);
        go <= 1'b0;
        @(negedge ref_clk);
        check(dbg_rsp, '{1'b1, 1'b1, 1'b0, AFF_B[63:32]});
        @(negedge ref_clk);
        check(dbg_rsp, '{1'b0, 1'b1, 1'b0, AFF_B[63:32]});
        // Reset in mid-run with a request pending
        @(posedge ref_clk);
        rst_n <= 1'b0;
        go    <= 1'b1;
        addr  <= 12'hfbc;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check(dbg_rsp, '{1'b0, 1'b0, 1'b0, 32'h0000_0000});
        @(posedge ref_clk);
        rst_n <= 1'b1;
        go    <= 1'b0;
        @(negedge ref_clk);
        check(dbg_rsp, '{1'b0, 1'b0, 1'b0, 32'h0000_0000});
        issue(1'b0, 12'hfcc);
        check(dbg_rsp, '{1'b1, 1'b1, 1'b0, 32'h0000_0016});
        stop_test();
    end
endmodule
